// ==== verilog/pwb_bridge.sv ====
// Behaviour
// - separate clear-only and set-only write locations
// - one to clear location unprotects peripheral
// - one to set location protects peripheral
// - both locations read the same vector
// - write to protected peripheral dropped, error
// - setting already protected bit is error
// - clearing already unprotected bit is error
// - high-speed slave reaching peripheral registers
// - peripheral bus with waits, errors, protection
// - address and data in one cycle
// - byte, half, word strobes, reads too
// - writing zero leaves protection unchanged
// - 8, 16, 32-bit guard accesses allowed
`timescale 1ns/10ps
`default_nettype none
`include "pwb_defines.svh"

module pwb_bridge
  import pwb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // high-speed bus slave side
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [3:0]  hprot_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // peripheral bus master side
  output logic      [31:0] paddr_out,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [31:0] pwdata_out,
  output logic      [3:0]  pstrb_out,
  output logic      [2:0]  pprot_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  // current protect vector
  output logic      [31:0] protect_vec_out
);

  // byte lanes touched by a transfer of given size and address
  // a word access always uses all four lanes
  function automatic logic [3:0] lanes(input logic [2:0] size,
                                       input logic [1:0] a);
    logic [3:0] l;
    l = 4'h0;
    unique case (size)
      3'h0:    l = 4'h1 << a;
      3'h1:    l = a[1] ? 4'hC : 4'h3;
      default: l = 4'hF;
    endcase
    return l;
  endfunction

  // byte lanes widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction

  pwb_guard_if gif (); // link to the protect register unit

  pwb_state_t  state_q;   // sequencer state
  pwb_state_t  state_d;   // next sequencer state
  pwb_state_t  accept_st; // state a new transfer would enter
  logic [31:0] addr_q;    // captured address
  logic        write_q;   // captured direction
  logic [2:0]  size_q;    // captured size
  logic [2:0]  prot_q;    // captured protection attributes

  // address phase decode
  wire         accept    = hsel_in & htrans_in[1] & hready_in;
  wire         acc_guard = haddr_in[`PWB_SLOT_HI:`PWB_SLOT_LO] == `PWB_GUARD_SLOT;
  // data or opcode and privilege map onto the peripheral attributes;
  // the secure attribute has no source here and stays low
  wire  [2:0]  acc_prot  = {~hprot_in[0], 1'b0, hprot_in[1]};

  // data phase decode
  wire  [4:0]  slot      = addr_q[`PWB_SLOT_HI:`PWB_SLOT_LO];
  wire  [9:0]  ofs       = addr_q[`PWB_OFS_HI:0];
  // byte and half-word accesses reach the word that holds them
  wire  [9:0]  ofs_word  = {ofs[9:2], 2'b00};
  wire         is_clr    = ofs_word == `PWB_OFS_CLEAR;
  wire         is_set    = ofs_word == `PWB_OFS_SET;
  wire         guard_hit = is_clr | is_set;
  wire  [3:0]  strb      = lanes(size_q, addr_q[1:0]);
  wire         blocked   = write_q & gif.vec[slot];

  // state names for decode
  wire st_idle   = state_q == PWB_IDLE;
  wire st_guard  = state_q == PWB_GUARD;
  wire st_setup  = state_q == PWB_SETUP;
  wire st_access = state_q == PWB_ACCESS;
  wire st_err    = state_q == PWB_ERR;

  // guard write: only ones in lanes written and bits that exist
  // bit zero is the guard's own slot and never protects
  assign gif.wr_en   = st_guard & write_q & guard_hit;
  assign gif.set_sel = is_set;
  assign gif.wmask   = hwdata_in & lane_mask(strb) & `PWB_PROT_IMPL;

  // refused guard writes and peripheral answers
  wire guard_err = gif.wr_en & gif.err;
  wire p_done    = st_access & pready_in;
  wire p_err     = p_done & pslverr_in;

  // protect register unit
  pwb_guard u_guard (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .gif    (gif)
  );

  // entry state for a transfer accepted in a completing cycle
  assign accept_st = !accept  ? PWB_IDLE
                   : acc_guard ? PWB_GUARD
                   : PWB_SETUP;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PWB_IDLE: begin
        // a new transfer picks its path by slot
        state_d = accept_st;
      end
      PWB_GUARD: begin
        // double protect or unprotect ends in error
        state_d = guard_err ? PWB_ERR : accept_st;
      end
      PWB_SETUP: begin
        // write to protected target: no peripheral cycle at all
        state_d = blocked ? PWB_ERR : PWB_ACCESS;
      end
      PWB_ACCESS: begin
        // wait states hold here
        if (p_err) begin
          state_d = PWB_ERR;
        end else if (p_done) begin
          state_d = accept_st;
        end
      end
      PWB_ERR: begin
        // second error cycle completes the transfer
        state_d = accept_st;
      end
      default: begin
        // illegal code falls back to idle
        state_d = PWB_IDLE;
      end
    endcase
  end

  // state register
  // sequencer falls back to idle on reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= PWB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // address phase capture, only when a transfer is taken
  // same cycles in which the bus sees ready high
  wire take = accept & (st_idle | (st_guard & ~guard_err)
                        | (p_done & ~pslverr_in) | st_err);

  // captured address phase fields
  // held through wait states for the peripheral
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q  <= 32'h0000_0000;
      write_q <= 1'b0;
      size_q  <= 3'h0;
      prot_q  <= 3'h0;
    end else if (take) begin
      addr_q  <= haddr_in;
      write_q <= hwrite_in;
      size_q  <= hsize_in;
      prot_q  <= acc_prot;
    end
  end

  // bus answer: error is two cycles, low ready then high ready
  // a blocked write answers in its setup cycle, no peripheral cycle
  assign hreadyout_out = st_idle | (st_guard & ~guard_err)
                       | (p_done & ~pslverr_in) | st_err;
  assign hresp_out     = guard_err | (st_setup & blocked)
                       | p_err | st_err;

  // read data: guard vector or peripheral data
  // other guard offsets read as zero
  assign hrdata_out = (st_guard & ~write_q & guard_hit) ? gif.vec
                    : st_access ? prdata_in
                    : 32'h0000_0000;

  // setup runs in the high-speed data phase, data held by the master
  assign psel_out    = (st_setup & ~blocked) | st_access;
  assign penable_out = st_access;
  assign paddr_out   = addr_q;
  assign pwrite_out  = write_q;
  assign pwdata_out  = hwdata_in;
  assign pstrb_out   = strb;
  assign pprot_out   = prot_q;

  // protect state for the rest of the chip
  assign protect_vec_out = gif.vec;

endmodule

`default_nettype wire

// ==== verilog/pwb_defines.svh ====
`ifndef PWB_DEFINES_SVH
`define PWB_DEFINES_SVH

// slot decode: each peripheral owns one 1 KB window of the bridge space
`define PWB_SLOT_HI      14
`define PWB_SLOT_LO      10
`define PWB_OFS_HI       9
// slot that holds the guard's own two locations
`define PWB_GUARD_SLOT   5'h00
// offsets inside the guard slot
`define PWB_OFS_CLEAR    10'h000
`define PWB_OFS_SET      10'h004
// protect vector after reset and the bits that exist
`define PWB_PROT_RESET   32'h0000_0000
`define PWB_PROT_IMPL    32'hFFFF_FFFE
// one-hot state codes
`define PWB_ST_IDLE      5'h01
`define PWB_ST_GUARD     5'h02
`define PWB_ST_SETUP     5'h04
`define PWB_ST_ACCESS    5'h08
`define PWB_ST_ERR       5'h10

`endif

// ==== verilog/pwb_pkg.sv ====
`include "pwb_defines.svh"

package pwb_pkg;
  // bridge sequencer states, one-hot
  typedef enum logic [4:0] {
    PWB_IDLE   = `PWB_ST_IDLE,
    PWB_GUARD  = `PWB_ST_GUARD,
    PWB_SETUP  = `PWB_ST_SETUP,
    PWB_ACCESS = `PWB_ST_ACCESS,
    PWB_ERR    = `PWB_ST_ERR
  } pwb_state_t;
  // one protect bit per peripheral slot
  typedef logic [31:0] pwb_vec_t;
endpackage

// ==== verilog/pwb_guard_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface pwb_guard_if;
  import pwb_pkg::*;
  logic     wr_en;   // write strobe to one of the two locations
  logic     set_sel; // 1 = set location, 0 = clear location
  pwb_vec_t wmask;   // ones written, after byte lanes
  pwb_vec_t vec;     // current protect vector
  logic     err;     // double protect or double unprotect

  modport bridge (output wr_en, output set_sel, output wmask, input vec, input err);
  modport guard  (input wr_en, input set_sel, input wmask, output vec, output err);
endinterface

`default_nettype wire

// ==== verilog/pwb_guard.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pwb_defines.svh"

module pwb_guard
  import pwb_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  pwb_guard_if.guard gif
);

  pwb_vec_t prot_q; // protect bits
  pwb_vec_t prot_d; // next protect bits

  // a one to an already set bit (set) or clear bit (clear) is refused
  assign gif.err = gif.set_sel ? |(gif.wmask & prot_q)
                               : |(gif.wmask & ~prot_q);

  // zeros leave bits alone; refused writes change nothing
  assign prot_d = (gif.wr_en & ~gif.err)
                ? (gif.set_sel ? (prot_q | gif.wmask)
                               : (prot_q & ~gif.wmask))
                : prot_q;

  // one vector seen through both locations
  assign gif.vec = prot_q;

  // protect state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prot_q <= `PWB_PROT_RESET;
    end else begin
      prot_q <= prot_d;
    end
  end

endmodule

`default_nettype wire

// ==== verif/pwb_bridge_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwb_bridge_checker (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] paddr_out,
  input wire logic        psel_out,
  input wire logic        penable_out,
  input wire logic        pwrite_out,
  input wire logic [3:0]  pstrb_out,
  input wire logic [31:0] prdata_in,
  input wire logic        pready_in,
  input wire logic        pslverr_in,
  input wire logic [31:0] protect_vec_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic tk = hsel_in & htrans_in[1] & hready_in & hreadyout_out; // taken request
  wire logic acs = psel_out & penable_out;                            // access cycle
  logic       acc_q; // first cycle of a data phase
  logic       wr_q;  // data phase is a write
  logic [4:0] slot_q; // slot of the data phase
  // track the data phase of each taken request
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q  <= 1'h0;
      wr_q   <= 1'h0;
      slot_q <= 5'h00;
    end else begin
      acc_q <= tk;
      if (tk) begin
        wr_q   <= hwrite_in;
        slot_q <= haddr_in[14:10];
      end
    end
  end
  // two-cycle error answer
  sequence err_pair;
    hresp_out && !hreadyout_out ##1 hresp_out && hreadyout_out;
  endsequence
  a_err_two_cycle: assert property ($rose(hresp_out) |-> err_pair)
    else $error("error answer not two cycles");
  a_prot_write_blocked: assert property (acc_q && wr_q && slot_q != 5'h00 &&
    protect_vec_out[slot_q] |-> err_pair and !psel_out [*2])
    else $error("protected write not blocked");
  a_setup_first: assert property (acc_q && slot_q != 5'h00 &&
    !(wr_q && protect_vec_out[slot_q]) |-> psel_out && !penable_out)
    else $error("no merged setup cycle");
  a_access_follows: assert property (psel_out && !penable_out |=> acs)
    else $error("setup not followed by access");
  a_ctl_stable: assert property (acs |-> $stable(paddr_out) && $stable(pwrite_out) &&
    $stable(pstrb_out)) else $error("peripheral controls moved");
  a_read_passes: assert property (acs && pready_in && !pwrite_out && !pslverr_in |->
    hreadyout_out && !hresp_out && hrdata_out == prdata_in)
    else $error("read data not passed");
  a_slverr_err: assert property (acs && pready_in && pslverr_in |-> ##[0:1] hresp_out)
    else $error("peripheral error lost");
  a_vec_guarded: assert property (!$stable(protect_vec_out) |-> $past(acc_q && wr_q &&
    slot_q == 5'h00)) else $error("protect vector changed alone");
endmodule
bind pwb_bridge pwb_bridge_checker pwb_bridge_checker_inst (.clk_in, .rst_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
  .paddr_out, .psel_out, .penable_out, .pwrite_out, .pstrb_out, .prdata_in, .pready_in,
  .pslverr_in, .protect_vec_out);
`default_nettype wire

// ==== verif/pwb_periph_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwb_periph_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic        err_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);
  logic [31:0] mem_q [32]; // one word per slot
  logic [3:0]  cnt_q;      // wait states so far
  wire logic [4:0] slot = paddr_in[14:10];
  assign pready_out  = psel_in & penable_in & (cnt_q == wait_in);
  assign pslverr_out = pready_out & err_in;
  // inverted data outside the ready cycle
  assign prdata_out = pready_out ? mem_q[slot] : ~mem_q[slot];
  // count wait states in the access cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) cnt_q <= 4'h0;
    else cnt_q <= (psel_in & penable_in & ~pready_out) ? cnt_q + 4'h1 : 4'h0;
  end
  // byte lanes honoured on write
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (pready_out && pwrite_in && !err_in && pstrb_in[i]) mem_q[slot][8*i+:8] <= pwdata_in[8*i+:8];
    end
  end
endmodule
`default_nettype wire

// ==== verif/pwb_bridge_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module pwb_bridge_bench;
  logic        clk_in = 0, rst_in = 1, hsel = 0, hwrite = 0, perr = 0, r, w, er;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0, sz, pprot;
  logic [3:0]  pwait = 4'h1, pstrb, hprot = 4'h3;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, paddr, pwdata, prdata, vec, q, a, d, eq;
  logic        hrdy, hresp, psel, pen, pwr, pready, pslverr;
  int          err_total = 0, n_compared = 0, cyc = 0;
  // addr, write, size, data, error, read data
  logic [100:0] rows [14] = '{
    {32'h0000_0C08, 1'h1, 3'h2, 32'h1234_5678, 1'h0, 32'h0000_0000},
    {32'h0000_0C09, 1'h1, 3'h0, 32'h0000_EE00, 1'h0, 32'h0000_0000},
    {32'h0000_0C08, 1'h0, 3'h2, 32'h0000_0000, 1'h0, 32'h1234_EE78},
    {32'h0000_0004, 1'h1, 3'h2, 32'h0000_0008, 1'h0, 32'h0000_0000},
    {32'h0000_0000, 1'h0, 3'h2, 32'h0000_0000, 1'h0, 32'h0000_0008},
    {32'h0000_0C08, 1'h1, 3'h2, 32'hAAAA_AAAA, 1'h1, 32'h0000_0000},
    {32'h0000_0C08, 1'h0, 3'h2, 32'h0000_0000, 1'h0, 32'h1234_EE78},
    {32'h0000_0004, 1'h1, 3'h2, 32'h0000_0008, 1'h1, 32'h0000_0000},
    {32'h0000_0004, 1'h0, 3'h2, 32'h0000_0000, 1'h0, 32'h0000_0008},
    {32'h0000_0000, 1'h1, 3'h2, 32'h0000_0008, 1'h0, 32'h0000_0000},
    {32'h0000_0000, 1'h1, 3'h2, 32'h0000_0008, 1'h1, 32'h0000_0000},
    {32'h0000_0005, 1'h1, 3'h0, 32'h0000_2000, 1'h0, 32'h0000_0000},
    {32'h0000_0000, 1'h1, 3'h2, 32'h0000_0000, 1'h0, 32'h0000_0000},
    {32'h0000_0004, 1'h0, 3'h2, 32'h0000_0000, 1'h0, 32'h0000_2000}};
  always #5 clk_in = ~clk_in;
  pwb_bridge pwb_bridge_inst (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hprot_in(hprot), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .paddr_out(paddr), .psel_out(psel),
    .penable_out(pen), .pwrite_out(pwr), .pwdata_out(pwdata), .pstrb_out(pstrb),
    .pprot_out(pprot), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
    .protect_vec_out(vec));
  pwb_periph_model pwb_periph_model_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .wait_in(pwait), .err_in(perr), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer: address phase, then data phase until ready
  task automatic xfer(input logic [31:0] ad, input logic wr, input logic [2:0] s,
                      input logic [31:0] dt);
    int k;
    @(posedge clk_in);
    hsel <= 1'h1; htrans <= 2'h2; haddr <= ad; hwrite <= wr; hsize <= s;
    @(posedge clk_in);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= dt;
    k = 0;
    do begin @(posedge clk_in); k++; end while (hrdy !== 1'h1 && k < 20);
    if (hrdy !== 1'h1) begin
      err_total++;
      $display("[FAIL] t=%0t ready %h exp %h", $time, hrdy, 1'h1);
    end
    r = hresp;
    q = hrdata;
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin err_total++; tally_and_finish; end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'h0;
    chk(vec, 32'h0000_0000);
    for (int i = 0; i < 14; i++) begin
      {a, w, sz, d, er, eq} = rows[i];
      xfer(a, w, sz, d);
      chk({31'h0, r}, {31'h0, er});
      if (!w) chk(q, eq);
    end
    pwait <= 4'h0;
    xfer(32'h0000_0C08, 1'h0, 3'h2, 32'h0);
    chk(q, 32'h1234_EE78);
    chk({29'h0, pprot}, 32'h0000_0001);
    chk(paddr, 32'h0000_0C08);
    perr <= 1'h1;
    hprot <= 4'h0;
    xfer(32'h0000_0C08, 1'h1, 3'h2, 32'h5555_5555);
    chk({31'h0, r}, 32'h1);
    chk({29'h0, pprot}, 32'h0000_0004);
    perr <= 1'h0;
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    xfer(32'h0000_0004, 1'h0, 3'h2, 32'h0);
    chk(q, 32'h0000_0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
